// ==== core/tbpwm_top.sv ====
// timer based pwm output: wishbone register file, port pin and modulator
// ----------------------------------------------------------------------
// Functional notes
// - period is (limit+1) times 4 clocks times prescale factor
// - count equal to limit clears the timer on next tick
// - pin goes high at restart unless duty is zero
// - duty copied into shadow byte and low latch at restart
// - duty is 10 bits: byte holds high eight, control 5:4 low two
// - high time is duty times one clock times prescale
// - duty writes accepted anytime, used from next period
// - shadow byte read-only in modulation mode
// - shadow byte plus 2-bit latch double-buffer the duty
// - pin cleared when buffered duty equals count with two fine bits
// - duty beyond period never clears pin
// - writing zero to control forces output latch low, port latch kept
// - prescaler divides by 1, 4 or 16
// - resolution is log2 of clock over output rate times prescale
// ----------------------------------------------------------------------
//
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
`include "tbpwm_regs.svh"
module tbpwm_top
    import tbpwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0] period_q;
    logic [6:0] tcon_q;
    logic [7:0] duty_q;
    logic [5:0] ccon_q;
    logic [7:0] dir_q;
    logic [7:0] port_q;
    logic [7:0] pie_q;
    logic tmr_flag_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic pin_s1_q;
    logic pin_s2_q;

    tbpwm_req_s req;
    tbpwm_cfg_s cfg;
    logic wr;
    logic rd;
    logic wr_lane0;
    logic tick;
    logic [1:0] fine;
    logic [7:0] count;
    logic [7:0] shadow;
    logic match;
    logic pwm;

    assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i};
    assign wr = wb_cyc_i && wb_stb_i && req.we && !ack_q;
    assign rd = wb_cyc_i && wb_stb_i && !req.we && !ack_q;
    assign wr_lane0 = wr && req.sel[0];

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction : hit

    // mode field 11xx selects modulation
    function automatic logic is_pwm(input logic [3:0] mode);
        is_pwm = (mode[3:2] == 2'b11);
    endfunction : is_pwm

    assign cfg.period_limit = period_q;
    assign cfg.run = tcon_q[`TBPWM_RUN_BIT];
    assign cfg.prescale = tbpwm_ps_e'(tcon_q[`TBPWM_PS_MSB:`TBPWM_PS_LSB]);
    assign cfg.pwm_mode = is_pwm(ccon_q[`TBPWM_MODE_MSB:`TBPWM_MODE_LSB]);

    // ------------------------------------------------------------------
    // wishbone slave: one wait-state ack, unmapped reads zero
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (rd) begin
            rdat_q <= 32'h0000_0000;
            unique case (req.adr)
                `TBPWM_OFF_PIR: rdat_q[7:0] <= {6'h00, tmr_flag_q, 1'b0};
                `TBPWM_OFF_CNT: rdat_q[7:0] <= count;
                `TBPWM_OFF_TCON: rdat_q[7:0] <= {1'b0, tcon_q};
                `TBPWM_OFF_DUTY: rdat_q[7:0] <= duty_q;
                `TBPWM_OFF_SHADOW: rdat_q[7:0] <= shadow;
                `TBPWM_OFF_CCON: rdat_q[7:0] <= {2'b00, ccon_q};
                `TBPWM_OFF_PORTB_DIR: rdat_q[7:0] <= dir_q;
                `TBPWM_OFF_PIE: rdat_q[7:0] <= pie_q;
                `TBPWM_OFF_PERIOD: rdat_q[7:0] <= period_q;
                `TBPWM_OFF_PORTB_DATA: begin
                    rdat_q[7:0] <= {port_q[7:4], pin_s2_q, port_q[2:0]};
                end
                default: rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            period_q <= `TBPWM_RST_PERIOD;
        end else if (wr_lane0 && hit(req.adr, `TBPWM_OFF_PERIOD)) begin
            period_q <= req.dat[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tcon_q <= `TBPWM_RST_TCON;
        end else if (wr_lane0 && hit(req.adr, `TBPWM_OFF_TCON)) begin
            tcon_q <= req.dat[6:0];
        end
    end

    // duty byte and low bits writable at any time
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_q <= `TBPWM_RST_ZERO;
        end else if (wr_lane0 && hit(req.adr, `TBPWM_OFF_DUTY)) begin
            duty_q <= req.dat[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ccon_q <= `TBPWM_RST_CCON;
        end else if (wr_lane0 && hit(req.adr, `TBPWM_OFF_CCON)) begin
            ccon_q <= req.dat[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= `TBPWM_RST_DIR;
        end else if (wr_lane0 && hit(req.adr, `TBPWM_OFF_PORTB_DIR)) begin
            dir_q <= req.dat[7:0];
        end
    end

    // general-purpose port data latch, untouched by control clears
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_q <= `TBPWM_RST_ZERO;
        end else if (wr_lane0 && hit(req.adr, `TBPWM_OFF_PORTB_DATA)) begin
            port_q <= req.dat[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pie_q <= `TBPWM_RST_ZERO;
        end else if (wr_lane0 && hit(req.adr, `TBPWM_OFF_PIE)) begin
            pie_q <= req.dat[7:0];
        end
    end

    // period-match flag: set wins over software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tmr_flag_q <= 1'b0;
        end else if (match) begin
            tmr_flag_q <= 1'b1;
        end else if (wr_lane0 && hit(req.adr, `TBPWM_OFF_PIR)) begin
            tmr_flag_q <= req.dat[`TBPWM_PIR_TMR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    // ------------------------------------------------------------------
    // time base and modulator
    // ------------------------------------------------------------------
    tbpwm_prescaler u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(cfg.run),
        .clear_i(wr_lane0 && hit(req.adr, `TBPWM_OFF_CNT)),
        .prescale_i(cfg.prescale),
        .tick_o(tick),
        .fine_o(fine)
    );

    // shadow write address is ignored: readable only
    tbpwm_modulator u_modulator (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_i(cfg),
        .tick_i(tick),
        .fine_i(fine),
        .duty_i({duty_q, ccon_q[`TBPWM_DLO_MSB:`TBPWM_DLO_LSB]}),
        .cnt_wr_i(wr_lane0 && hit(req.adr, `TBPWM_OFF_CNT)),
        .cnt_wdat_i(req.dat[7:0]),
        .force_low_i(wr_lane0 && hit(req.adr, `TBPWM_OFF_CCON) && req.dat[5:0] == 6'h00),
        .count_o(count),
        .shadow_o(shadow),
        .match_o(match),
        .pwm_o(pwm)
    );

    // pin drives when direction bit 3 is clear
    assign pin_oe_o = !dir_q[`TBPWM_PIN_BIT];
    assign pin_o = cfg.pwm_mode ? pwm : port_q[`TBPWM_PIN_BIT];
endmodule : tbpwm_top

// ==== inc/tbpwm_regs.svh ====
// register offsets, field positions, reset values and timing counts of the pwm block
`ifndef TBPWM_REGS_SVH
`define TBPWM_REGS_SVH

`define TBPWM_OFF_PIR 8'h0c
`define TBPWM_OFF_CNT 8'h11
`define TBPWM_OFF_TCON 8'h12
`define TBPWM_OFF_DUTY 8'h15
`define TBPWM_OFF_SHADOW 8'h16
`define TBPWM_OFF_CCON 8'h17
`define TBPWM_OFF_PORTB_DIR 8'h86
`define TBPWM_OFF_PIE 8'h8c
`define TBPWM_OFF_PERIOD 8'h92
`define TBPWM_OFF_PORTB_DATA 8'h06

`define TBPWM_RST_PERIOD 8'hff
`define TBPWM_RST_CNT 8'h00
`define TBPWM_RST_TCON 7'h00
`define TBPWM_RST_CCON 6'h00
`define TBPWM_RST_DIR 8'hff
`define TBPWM_RST_ZERO 8'h00

`define TBPWM_PIN_BIT 3
`define TBPWM_RUN_BIT 2
`define TBPWM_PS_MSB 1
`define TBPWM_PS_LSB 0
`define TBPWM_DLO_MSB 5
`define TBPWM_DLO_LSB 4
`define TBPWM_MODE_MSB 3
`define TBPWM_MODE_LSB 0
`define TBPWM_PIR_TMR_BIT 1

`define TBPWM_QUARTER_CYCLES 4
`define TBPWM_PS_MAX 16

`endif

// ==== inc/tbpwm_pkg.sv ====
// types of the timer based pwm block
package tbpwm_pkg;

    typedef enum logic [1:0] {
        TBPWM_PS_1 = 2'b00,
        TBPWM_PS_4 = 2'b01,
        TBPWM_PS_16A = 2'b10,
        TBPWM_PS_16B = 2'b11
    } tbpwm_ps_e;

    typedef struct packed {
        logic [7:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } tbpwm_req_s;

    typedef struct packed {
        logic [7:0] period_limit;
        logic run;
        tbpwm_ps_e prescale;
        logic pwm_mode;
    } tbpwm_cfg_s;

    typedef enum logic [2:0] {
        TBPWM_BUS_IDLE = 3'b001,
        TBPWM_BUS_ACK = 3'b010,
        TBPWM_BUS_HOLD = 3'b100
    } tbpwm_bus_e;

endpackage : tbpwm_pkg

// ==== core/tbpwm_prescaler.sv ====
// tick divider: quarter-cycle phase and period-timer prescaler
`timescale 1ns/10ps
`include "tbpwm_regs.svh"
module tbpwm_prescaler
    import tbpwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic clear_i,
    input wire tbpwm_ps_e prescale_i,
    output logic tick_o,
    output logic [1:0] fine_o
);
    logic [5:0] div_q;
    logic [5:0] div_d;
    logic [5:0] last;

    // 4 clocks per tick times 1, 4 or 16
    always_comb begin
        unique case (prescale_i)
            TBPWM_PS_1: last = 6'h03;
            TBPWM_PS_4: last = 6'h0f;
            default: last = 6'h3f;
        endcase
    end

    always_comb begin
        if (clear_i || !run_i || div_q >= last) begin
            div_d = 6'h00;
        end else begin
            div_d = div_q + 6'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 6'h00;
        end else begin
            div_q <= div_d;
        end
    end

    assign tick_o = run_i && (div_q >= last);

    // sub-tick bits of the coming clock, so the registered pin falls on time
    always_comb begin
        unique case (prescale_i)
            TBPWM_PS_1: fine_o = div_d[1:0];
            TBPWM_PS_4: fine_o = div_d[3:2];
            default: fine_o = div_d[5:4];
        endcase
    end
endmodule : tbpwm_prescaler

// ==== core/tbpwm_modulator.sv ====
// period timer, duty double buffer and output latch
`timescale 1ns/10ps
`include "tbpwm_regs.svh"
module tbpwm_modulator
    import tbpwm_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire tbpwm_cfg_s cfg_i,
    input wire logic tick_i,
    input wire logic [1:0] fine_i,
    input wire logic [9:0] duty_i,
    input wire logic cnt_wr_i,
    input wire logic [7:0] cnt_wdat_i,
    input wire logic force_low_i,
    output logic [7:0] count_o,
    output logic [7:0] shadow_o,
    output logic match_o,
    output logic pwm_o
);
    logic [7:0] cnt_q;
    logic [1:0] latch_q;
    logic [7:0] shadow_q;
    logic out_q;
    logic restart;
    logic [7:0] cnt_next;

    assign restart = tick_i && (cnt_q == cfg_i.period_limit);
    // count of the coming clock: the compare looks one clock ahead
    assign cnt_next = tick_i ? cnt_q + 8'h01 : cnt_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= `TBPWM_RST_CNT;
        end else if (cnt_wr_i) begin
            cnt_q <= cnt_wdat_i;
        end else if (restart) begin
            cnt_q <= `TBPWM_RST_CNT;
        end else if (tick_i) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // shadow loads only at period restart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow_q <= `TBPWM_RST_ZERO;
            latch_q <= 2'b00;
        end else if (restart && cfg_i.pwm_mode) begin
            shadow_q <= duty_i[9:2];
            latch_q <= duty_i[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || force_low_i) begin
            out_q <= 1'b0;
        end else if (!cfg_i.pwm_mode) begin
            out_q <= 1'b0;
        end else if (restart) begin
            out_q <= (duty_i != 10'h000);
        end else if (cfg_i.run && {shadow_q, latch_q} == {cnt_next, fine_i}) begin
            out_q <= 1'b0;
        end
    end

    assign count_o = cnt_q;
    assign shadow_o = shadow_q;
    assign match_o = restart;
    assign pwm_o = out_q;
endmodule : tbpwm_modulator

// ==== verification/tbpwm_sva.sv ====
// port checker of the timer based pwm block
`timescale 1ns/10ps
module tbpwm_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic pin_i,
    input wire logic pin_o,
    input wire logic pin_oe_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic req;
    logic dir_wr;
    assign req = wb_cyc_i && wb_stb_i;
    assign dir_wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h86;
    AST_ACK_NEXT:
        assert property (req && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    AST_ACK_ONE:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_ACK_CAUSE:
        assert property (!req |=> !wb_ack_o) else $error("ack without request");
    AST_RD_UPPER:
        assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits set");
    AST_UNMAPPED:
        assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h40 |-> wb_dat_o == 32'h0)
            else $error("unmapped read not zero");
    AST_OE_DIR:
        assert property (wb_ack_o && dir_wr |=> pin_oe_o == !$past(wb_dat_i[3]))
            else $error("pin enable not from direction bit");
    AST_OE_HOLD:
        assert property (!$stable(pin_oe_o) |-> $past(dir_wr)) else $error("enable moved");
    AST_RST_VAL:
        assert property ($fell(rst_i) |-> !pin_oe_o && !pin_o && !wb_ack_o)
            else $error("reset values wrong");
    cover property (req && wb_we_i && wb_ack_o);
    cover property (pin_oe_o && $rose(pin_o));
    cover property (pin_oe_o && $fell(pin_o));
endmodule : tbpwm_sva

// ==== verification/tbpwm_load.sv ====
// load on the modulated pin: measures period and high time
`timescale 1ns/10ps
module tbpwm_load (
    input wire logic clk_i,
    input wire logic pin_o,
    input wire logic pin_oe_o,
    output logic pin_lvl_o,
    output int rises_o,
    output int falls_o,
    output int period_o,
    output int high_o
);
    int t_q = 0;
    int rt_q = 0;
    logic last_q = 1'b0;
    logic flip_q = 1'b0;
    // released pin wanders every cycle so a stale level is never trusted
    assign pin_lvl_o = pin_oe_o ? pin_o : flip_q;
    always @(posedge clk_i) begin
        t_q <= t_q + 1;
        flip_q <= ~flip_q;
        last_q <= pin_o;
        if (pin_oe_o && pin_o && !last_q) begin
            rises_o <= rises_o + 1;
            period_o <= t_q - rt_q;
            rt_q <= t_q;
        end
        if (pin_oe_o && !pin_o && last_q) begin
            falls_o <= falls_o + 1;
            high_o <= t_q - rt_q;
        end
    end
endmodule : tbpwm_load

// ==== verification/tb_top.sv ====
// self-checking bench of the pwm block with a register model
`timescale 1ns/10ps
module tb_top
    import tbpwm_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    tbpwm_req_s rq = '0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic ack;
    logic pin_lvl;
    logic pin_o;
    logic pin_oe;
    int rises, falls, period, high;
    int fails = 0;
    int n_tests = 0;
    int seed = 81;
    int per = 0;
    int msk [int] = '{8'h12: 8'h7f, 8'h17: 8'h3f, 8'h15: 8'hff, 8'h92: 8'hff, 8'h86: 8'hff,
        8'h8c: 8'hff};
    int mdl [int] = '{8'h11: 0, 8'h12: 0, 8'h17: 0, 8'h92: 8'hff, 8'h86: 8'hff, 8'h8c: 0};
    logic [7:0] rl [6] = '{8'h11, 8'h12, 8'h17, 8'h92, 8'h86, 8'h8c};
    logic [7:0] wl [6] = '{8'h12, 8'h17, 8'h15, 8'h92, 8'h86, 8'h8c};
    always #2 clk_i = ~clk_i;
    tbpwm_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(rq.we), .wb_adr_i(rq.adr), .wb_sel_i(rq.sel), .wb_dat_i(rq.dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_lvl), .pin_o(pin_o), .pin_oe_o(pin_oe));
    tbpwm_load u_load (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe), .pin_lvl_o(pin_lvl),
        .rises_o(rises), .falls_o(falls), .period_o(period), .high_o(high));
    // ----------------------------------------------------------------
    // bus and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        {cyc, stb} <= 2'b11;
        rq <= '{a, w, s, {24'h0, d}};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 16) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 16, 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
        @(posedge clk_i);
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, 4'hf);
        if (msk.exists(a)) mdl[a] = d & msk[a];
    endtask : wr
    task automatic rdc(input logic [7:0] a);
        bus(a, 1'b0, 8'h00, 4'hf);
        chk(q, mdl[a]);
    endtask : rdc
    task automatic wait_rises(input int k);
        int r0;
        int n;
        r0 = rises;
        n = 0;
        while (rises < r0 + k && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 20000, 1'b1);
    endtask : wait_rises
    task automatic run_pwm(input logic [1:0] ps, input logic [7:0] lim, input logic [9:0] dt);
        int f;
        f = (ps == 2'b00) ? 1 : (ps == 2'b01) ? 4 : 16;
        per = (lim + 1) * 4 * f;
        wr(8'h12, 8'h00);
        wr(8'h11, 8'h00);
        wr(8'h92, lim);
        wr(8'h15, dt[9:2]);
        wr(8'h17, {2'b00, dt[1:0], 4'hc});
        wr(8'h86, 8'hf7);
        wr(8'h12, {5'b00000, 1'b1, ps});
        wait_rises(3);
        chk(period, per);
        chk(high, dt * f);
        bus(8'h16, 1'b0, 8'h00, 4'hf);
        chk(q, {24'h0, dt[9:2]});
        $display("test prescale %0d done", f);
    endtask : run_pwm
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        repeat (60000) @(posedge clk_i);
        fails++;
        give_verdict();
    end
    initial begin
        logic [7:0] lim;
        logic [9:0] dt;
        logic [9:0] nd;
        int n0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rl[i]) rdc(rl[i]);
        $display("test reset values done");
        for (int i = 0; i < 10; i++) begin
            wr(wl[i % 6], 8'($random(seed)));
            rdc(wl[i % 6]);
        end
        bus(8'h92, 1'b1, 8'h5a, 4'h0);
        rdc(8'h92);
        bus(8'h40, 1'b1, 8'h5a, 4'hf);
        bus(8'h40, 1'b0, 8'h00, 4'hf);
        chk(q, 32'h0);
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            lim = 8'(4 + ($random(seed) & 7));
            dt = 10'(1 + (($random(seed) & 255) % ((lim + 1) * 4 - 1)));
            run_pwm(p[1:0], lim, dt);
        end
        nd = 10'(1 + (dt + 7) % ((lim + 1) * 4 - 1));
        wr(8'h15, nd[9:2]);
        wr(8'h17, {2'b00, nd[1:0], 4'hc});
        wait_rises(3);
        chk(high, nd * 16);
        $display("test duty update done");
        wr(8'h15, 8'h00);
        wr(8'h17, 8'h0c);
        repeat (2 * per) @(posedge clk_i);
        n0 = rises;
        repeat (2 * per) @(posedge clk_i);
        chk(rises, n0);
        chk(pin_o, 1'b0);
        bus(8'h0c, 1'b0, 8'h00, 4'hf);
        chk(q, 32'h0000_0002);
        $display("test zero duty done");
        wr(8'h15, 8'hff);
        wr(8'h17, 8'h3c);
        repeat (2 * per) @(posedge clk_i);
        n0 = falls;
        repeat (2 * per) @(posedge clk_i);
        chk(falls, n0);
        chk(pin_o, 1'b1);
        bus(8'h16, 1'b1, 8'h00, 4'hf);
        bus(8'h16, 1'b0, 8'h00, 4'hf);
        chk(q, 32'h0000_00ff);
        $display("test long duty done");
        wr(8'h12, 8'h00);
        bus(8'h0c, 1'b1, 8'h00, 4'hf);
        bus(8'h0c, 1'b0, 8'h00, 4'hf);
        chk(q, 32'h0000_0000);
        wr(8'h06, 8'h08);
        wr(8'h17, 8'h00);
        chk(pin_o, 1'b1);
        bus(8'h06, 1'b0, 8'h00, 4'hf);
        chk(q, 32'h0000_0008);
        wr(8'h17, 8'h0c);
        chk(pin_o, 1'b0);
        $display("test control clear done");
        give_verdict();
    end
endmodule : tb_top
bind tbpwm_top tbpwm_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o));
